// *** src/pecs_regs.svh ***
`ifndef PECS_REGS_SVH
`define PECS_REGS_SVH
// Register block byte offsets
`define PECS_EVT_OFS 8'h00
`define PECS_FLT_OFS 8'h20
`define PECS_CNT_OFS 8'h40
`define PECS_SHD_OFS 8'h60
`define PECS_CTRL_OFS 8'h80
`define PECS_STAT_OFS 8'h84
// Control register fields
`define PECS_CTRL_EN_LSB 0
`define PECS_CTRL_NS_BIT 8
`define PECS_CTRL_CAP_BIT 16
`define PECS_CTRL_RESET 32'h0000_0000
// Status register fields
`define PECS_STAT_HOLD_BIT 0
`define PECS_STAT_PEND_LSB 8
// Filter register fields
`define PECS_FLT_TYPE_MSB 31
`define PECS_FLT_TYPE_LSB 30
`define PECS_FLT_ENC_BIT 29
`define PECS_FLT_VAL_MSB 15
`define PECS_FLT_RESET 32'h0000_0000
`define PECS_EVT_RESET 8'h00
// Event codes
`define PECS_EV_ACC 8'h80
`define PECS_EV_COUNTER_OVERFLOW_EVENT 8'h81
`define PECS_EV_SET_VIRT 8'h88
`define PECS_EV_REL_VIRT 8'h89
`define PECS_EV_ACT_VLPI 8'h8a
`define PECS_EV_ACT_VSGI 8'h8b
`define PECS_EV_SET_COMP 8'h8c
`define PECS_EV_RT_FIRST 8'h90
`define PECS_EV_RT_DEACT 8'h93
`define PECS_EV_RT_PEND 8'h94
`define PECS_EV_RT_ACT 8'h95
`endif

// *** src/pecs_pkg.sv ***
package pecs_pkg;
  // Filter match subject
  typedef enum logic [1:0] {
    PECS_SUBJ_CORE = 2'h0,
    PECS_SUBJ_INTID = 2'h1,
    PECS_SUBJ_CHIP = 2'h2,
    PECS_SUBJ_NONE = 2'h3
  } pecs_subj_t;
  // Low-power channel handshake states
  typedef enum logic [2:0] {
    PECS_QC_RUN = 3'h1,
    PECS_QC_STOP = 3'h2,
    PECS_QC_DENY = 3'h4
  } pecs_qc_t;
endpackage

// *** src/pecs_slot_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface pecs_slot_if #(parameter int W = 32);
  logic en;
  logic load;
  logic capture;
  logic ovf_ok;
  logic [W-1:0] load_val;
  logic [W-1:0] inc;
  logic [W-1:0] count;
  logic [W-1:0] shadow;
  logic ovf;
  modport slot (input en, load, capture, ovf_ok, load_val, inc, output count, shadow, ovf);
  modport ctrl (output en, load, capture, ovf_ok, load_val, inc, input count, shadow, ovf);
endinterface
`default_nettype wire

// *** src/pecs_filter_match.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "pecs_regs.svh"
module pecs_filter_match
  import pecs_pkg::*;
(
  // Filter setup
  input wire logic [31:0] cfg,
  // Event attributes
  input wire logic [15:0] core,
  input wire logic [15:0] intid,
  input wire logic [15:0] chip,
  // Result
  output logic hit
);
  logic [15:0] val;
  logic [15:0] subj;
  logic [15:0] care;
  pecs_subj_t typ;

  // Subject pick, exact or masked-range compare
  always_comb begin
    typ = pecs_subj_t'(cfg[`PECS_FLT_TYPE_MSB:`PECS_FLT_TYPE_LSB]);
    val = cfg[`PECS_FLT_VAL_MSB:0];
    unique case (typ)
      PECS_SUBJ_CORE: subj = core;
      PECS_SUBJ_INTID: subj = intid;
      PECS_SUBJ_CHIP: subj = chip;
      PECS_SUBJ_NONE: subj = 16'h0000;
    endcase
    // Range mode ignores bits up to the first zero
    care = cfg[`PECS_FLT_ENC_BIT] ? 16'hffff : ~(val ^ (val + 16'h0001));
    hit = (typ == PECS_SUBJ_NONE) || ((subj & care) == (val & care));
  end
endmodule // pecs_filter_match
`default_nettype wire

// *** src/pecs_counter_slot.sv ***
`timescale 1ns/1ns
`default_nettype none
module pecs_counter_slot #(
  parameter int W = 32
) (
  // Clocking
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Counter controls
  pecs_slot_if.slot s
);
  logic [W-1:0] count_reg, count_next, shadow_reg, shadow_next;
  logic ovf_reg, ovf_next;
  logic [W:0] sum;

  // Next count, wrap flag and shadow
  always_comb begin
    sum = {1'b0, count_reg} + {1'b0, s.inc};
    count_next = count_reg;
    ovf_next = 1'b0;
    if (s.load) begin
      count_next = s.load_val;
    end else if (s.en) begin
      count_next = sum[W-1:0];
      ovf_next = s.ovf_ok & sum[W];
    end
    shadow_next = s.capture ? count_reg : shadow_reg;
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count_reg <= '0;
      shadow_reg <= '0;
      ovf_reg <= 1'b0;
    end else if (ce) begin
      count_reg <= count_next;
      shadow_reg <= shadow_next;
      ovf_reg <= ovf_next;
    end
  end

  assign s.count = count_reg;
  assign s.shadow = shadow_reg;
  assign s.ovf = ovf_reg;

  property p_hold_disabled;
    @(posedge sys_clk) disable iff (!rst_n)
      ce && !s.en && !s.load |=> count_reg == $past(count_reg);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled) else $error("disabled counter changed");

  property p_shadow_capture;
    @(posedge sys_clk) disable iff (!rst_n)
      ce && s.capture |=> (shadow_reg == $past(count_reg)) ##1 (!ce || s.capture || $stable(shadow_reg));
  endproperty
  a_shadow_capture: assert property (p_shadow_capture) else $error("shadow not captured or drifted");
endmodule // pecs_counter_slot
`default_nettype wire

// *** src/pecs_top.sv ***
// Operation
// - Code 0x80 adds counter n-1 minus counter n-2 each cycle, no clock gating.
// - Code 0x81 counts overflows of counter n-1, unless that one counts overflows.
// - Code 0x8C counts set then activate, and decrements on release.
// - Real-time events 0x90 to 0x93 use filter register three; 0x94 and 0x95 are not filtered.
// - Code 0x93 counts nothing while filter register three is set.
// - Code 0x94 adds pending real-time count per cycle; low-power requests refused.
// - Code 0x95 adds active real-time count per cycle; low-power requests refused.
// - Five counters, each with a 32-bit shadow value register.
// - Shadow holds the captured counter value until the next capture.
// - Event type registers need secure access while the nonsecure bit is 0.
// - Shadow registers need secure access while the nonsecure bit is 0.
// - Filter type selects core, identifier, chip, or no effect.
// - Encoding 1 matches exactly; 0 ignores low bits up to first zero.
`timescale 1ns/1ns
`default_nettype none
`include "pecs_regs.svh"
module pecs_top
  import pecs_pkg::*;
#(
  parameter int NUM_CNT = 5,
  parameter int CNT_W = 32,
  parameter int RT_CNT_W = 8
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_secure,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // General event report
  input wire logic ev_valid,
  input wire logic [7:0] ev_code,
  input wire logic [15:0] ev_core,
  input wire logic [15:0] ev_intid,
  input wire logic [15:0] ev_chip,
  // Real-time shared interrupt report
  input wire logic rt_valid,
  input wire logic [7:0] rt_code,
  input wire logic [15:0] rt_target,
  input wire logic [15:0] rt_intid,
  input wire logic [RT_CNT_W-1:0] rt_pend_cnt,
  input wire logic [RT_CNT_W-1:0] rt_act_cnt,
  output logic [31:0] rt_filter_cfg,
  // Shadow capture strobe
  input wire logic shadow_capture,
  // Low-power channel
  input wire logic qreqn,
  output logic qacceptn,
  output logic qdenyn,
  output logic qactive
);
  localparam int IW = $clog2(NUM_CNT);

  logic [7:0] evt_reg [NUM_CNT];
  logic [7:0] evt_next [NUM_CNT];
  logic [31:0] flt_reg [NUM_CNT];
  logic [31:0] flt_next [NUM_CNT];
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic [NUM_CNT-1:0] pend_reg;
  logic set_pend_next [NUM_CNT];
  pecs_qc_t qc_reg, qc_next;

  logic [CNT_W-1:0] cnt_val [NUM_CNT];
  logic [CNT_W-1:0] shd_val [NUM_CNT];
  logic [CNT_W-1:0] inc_val [NUM_CNT];
  logic ovf_ok [NUM_CNT];
  logic [NUM_CNT-1:0] ovf_val, flt_hit, cnt_load;
  logic rt_hit, rt_filter_set, hold, sel_pend, sel_act;
  logic req, wr_take, sec_ok, cap_req;
  logic [2:0] blk;
  logic [IW-1:0] idx;
  logic idx_ok;
  logic [31:0] wmask;

  pecs_slot_if #(.W(CNT_W)) slot [NUM_CNT] ();

  // Bus decode and byte lanes
  assign req = avs_read | avs_write;
  assign wr_take = avs_write & ack_reg;
  assign blk = avs_address[7:5];
  assign idx = avs_address[IW+1:2];
  assign idx_ok = (avs_address[4:2] < 3'(NUM_CNT));
  assign sec_ok = ctrl_reg[`PECS_CTRL_NS_BIT] | avs_secure;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign avs_waitrequest = req & ~ack_reg;
  assign avs_readdata = rdata_reg;
  assign cap_req = shadow_capture | (wr_take & (avs_address == `PECS_CTRL_OFS) & avs_byteenable[2]
                                     & avs_writedata[`PECS_CTRL_CAP_BIT]);

  // Real-time filtering always through filter register three
  assign rt_filter_cfg = flt_reg[3];
  assign rt_filter_set = flt_reg[3][`PECS_FLT_TYPE_MSB:`PECS_FLT_TYPE_LSB] != PECS_SUBJ_NONE;
  pecs_filter_match u_rt_match (
    .cfg(flt_reg[3]),
    .core(rt_target),
    .intid(rt_intid),
    .chip(16'h0000),
    .hit(rt_hit)
  );

  // Counter slots and per-counter increment
  genvar n;
  generate
    for (n = 0; n < NUM_CNT; n++) begin : g_cnt
      logic [CNT_W-1:0] acc_diff;
      logic prev_ovf;
      logic prev_is_counter_overflow_event;
      if (n >= 2) begin : g_acc
        assign acc_diff = cnt_val[n-1] - cnt_val[n-2];
      end else begin : g_noacc
        assign acc_diff = '0;
      end
      if (n >= 1) begin : g_ovf
        assign prev_ovf = ovf_val[n-1];
        assign prev_is_counter_overflow_event = (evt_reg[n-1] == `PECS_EV_COUNTER_OVERFLOW_EVENT);
      end else begin : g_noovf
        assign prev_ovf = 1'b0;
        assign prev_is_counter_overflow_event = 1'b0;
      end

      pecs_filter_match u_match (
        .cfg(flt_reg[n]),
        .core(ev_core),
        .intid(ev_intid),
        .chip(ev_chip),
        .hit(flt_hit[n])
      );

      pecs_counter_slot #(.W(CNT_W)) u_slot (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ce(ce),
        .s(slot[n].slot)
      );

      assign cnt_load[n] = wr_take & (blk == 3'h2) & (idx == IW'(n));
      assign slot[n].en = ctrl_reg[`PECS_CTRL_EN_LSB + n];
      assign slot[n].load = cnt_load[n];
      assign slot[n].load_val = (cnt_val[n] & ~wmask) | (avs_writedata & wmask);
      assign slot[n].capture = cap_req;
      assign slot[n].inc = inc_val[n];
      assign slot[n].ovf_ok = ovf_ok[n];
      assign cnt_val[n] = slot[n].count;
      assign shd_val[n] = slot[n].shadow;
      assign ovf_val[n] = slot[n].ovf;

      // Event qualification for this counter
      always_comb begin
        inc_val[n] = '0;
        ovf_ok[n] = 1'b1;
        set_pend_next[n] = pend_reg[n];
        case (evt_reg[n])
          `PECS_EV_ACC: inc_val[n] = acc_diff;
          `PECS_EV_COUNTER_OVERFLOW_EVENT: inc_val[n] = CNT_W'(prev_ovf & ~prev_is_counter_overflow_event);
          `PECS_EV_SET_COMP: begin
            if (ev_valid & flt_hit[n]) begin
              if (ev_code == `PECS_EV_SET_VIRT) begin
                set_pend_next[n] = 1'b1;
              end else if (pend_reg[n] & ((ev_code == `PECS_EV_ACT_VLPI) | (ev_code == `PECS_EV_ACT_VSGI))) begin
                inc_val[n] = CNT_W'(1);
                set_pend_next[n] = 1'b0;
              end else if (ev_code == `PECS_EV_REL_VIRT) begin
                inc_val[n] = '1;
                ovf_ok[n] = 1'b0;
              end
            end
          end
          `PECS_EV_RT_DEACT: inc_val[n] = CNT_W'(rt_valid & (rt_code == evt_reg[n]) & ~rt_filter_set);
          `PECS_EV_RT_PEND: inc_val[n] = CNT_W'(rt_pend_cnt);
          `PECS_EV_RT_ACT: inc_val[n] = CNT_W'(rt_act_cnt);
          default: begin
            if ((evt_reg[n] >= `PECS_EV_RT_FIRST) & (evt_reg[n] < `PECS_EV_RT_DEACT)) begin
              inc_val[n] = CNT_W'(rt_valid & (rt_code == evt_reg[n]) & rt_hit);
            end else begin
              inc_val[n] = CNT_W'(ev_valid & (ev_code == evt_reg[n]) & flt_hit[n]);
            end
          end
        endcase
      end
    end
  endgenerate

  // Selections that keep the clock running
  always_comb begin
    sel_pend = 1'b0;
    sel_act = 1'b0;
    hold = 1'b0;
    for (int i = 0; i < NUM_CNT; i++) begin
      sel_pend |= (evt_reg[i] == `PECS_EV_RT_PEND);
      sel_act |= (evt_reg[i] == `PECS_EV_RT_ACT);
      hold |= (evt_reg[i] == `PECS_EV_ACC);
    end
    hold = hold | sel_pend | sel_act;
  end

  // Low-power channel handshake
  always_comb begin
    qc_next = qc_reg;
    unique case (qc_reg)
      PECS_QC_RUN: if (!qreqn) qc_next = hold ? PECS_QC_DENY : PECS_QC_STOP;
      PECS_QC_STOP: if (qreqn) qc_next = PECS_QC_RUN;
      PECS_QC_DENY: if (qreqn) qc_next = PECS_QC_RUN;
      default: qc_next = PECS_QC_RUN;
    endcase
  end
  assign qacceptn = (qc_reg != PECS_QC_STOP);
  assign qdenyn = (qc_reg != PECS_QC_DENY);
  assign qactive = hold;

  // Register writes and read data
  always_comb begin
    evt_next = evt_reg;
    flt_next = flt_reg;
    ctrl_next = ctrl_reg;
    ack_next = req & ~ack_reg;
    rdata_next = rdata_reg;
    if (wr_take) begin
      unique case (blk)
        3'h0: if (idx_ok & sec_ok & avs_byteenable[0]) evt_next[idx] = avs_writedata[7:0];
        3'h1: if (idx_ok & sec_ok) flt_next[idx] = ((flt_reg[idx] & ~wmask) | (avs_writedata & wmask))
                                                   & 32'he000_ffff;
        3'h4: if (avs_address == `PECS_CTRL_OFS) begin
          ctrl_next = ((ctrl_reg & ~wmask) | (avs_writedata & wmask)) & 32'h0000_011f;
        end
        default: ;
      endcase
    end
    if (req & ~ack_reg) begin
      rdata_next = 32'h0000_0000;
      unique case (blk)
        3'h0: if (idx_ok & sec_ok) rdata_next = {24'h000000, evt_reg[idx]};
        3'h1: if (idx_ok & sec_ok) rdata_next = flt_reg[idx];
        3'h2: if (idx_ok) rdata_next = cnt_val[idx];
        3'h3: if (idx_ok & sec_ok) rdata_next = shd_val[idx];
        3'h4: begin
          if (avs_address == `PECS_CTRL_OFS) rdata_next = ctrl_reg;
          if (avs_address == `PECS_STAT_OFS) begin
            rdata_next = {19'h00000, NUM_CNT'(pend_reg), 7'h00, hold};
          end
        end
        default: ;
      endcase
    end
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        evt_reg[i] <= `PECS_EVT_RESET;
        flt_reg[i] <= `PECS_FLT_RESET;
      end
      ctrl_reg <= `PECS_CTRL_RESET;
      rdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
      pend_reg <= '0;
      qc_reg <= PECS_QC_RUN;
    end else if (ce) begin
      evt_reg <= evt_next;
      flt_reg <= flt_next;
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      for (int i = 0; i < NUM_CNT; i++) begin
        pend_reg[i] <= set_pend_next[i];
      end
      qc_reg <= qc_next;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_acc_diff;
    ce && ctrl_reg[2] && evt_reg[2] == `PECS_EV_ACC && !cnt_load[2]
      |=> cnt_val[2] == $past(cnt_val[2]) + $past(cnt_val[1]) - $past(cnt_val[0]);
  endproperty
  a_acc_diff: assert property (p_acc_diff) else $error("difference event added wrong amount");

  property p_counter_overflow_event_chain;
    ce && ctrl_reg[1] && evt_reg[1] == `PECS_EV_COUNTER_OVERFLOW_EVENT && !cnt_load[1]
      |=> cnt_val[1] == $past(cnt_val[1]) + CNT_W'($past(ovf_val[0]) && $past(evt_reg[0]) != `PECS_EV_COUNTER_OVERFLOW_EVENT);
  endproperty
  a_counter_overflow_event_chain: assert property (p_counter_overflow_event_chain) else $error("overflow chain miscounted");

  property p_rt_uses_reg3;
    ce && ctrl_reg[4] && evt_reg[4] == `PECS_EV_RT_FIRST && !cnt_load[4] && rt_valid
      && rt_code == `PECS_EV_RT_FIRST && !rt_hit |=> $stable(cnt_val[4]);
  endproperty
  a_rt_uses_reg3: assert property (p_rt_uses_reg3) else $error("real-time event passed filter three");

  property p_deact_filtered;
    ce && evt_reg[4] == `PECS_EV_RT_DEACT && rt_filter_set && !cnt_load[4] |=> $stable(cnt_val[4]);
  endproperty
  a_deact_filtered: assert property (p_deact_filtered) else $error("deactivate counted with filter set");

  property p_pend_deny;
    ce && sel_pend && qc_reg == PECS_QC_RUN && !qreqn |=> !qdenyn && qacceptn;
  endproperty
  a_pend_deny: assert property (p_pend_deny) else $error("low-power accepted with pending count");

  property p_act_deny;
    ce && sel_act && qc_reg == PECS_QC_RUN && !qreqn |=> qacceptn ##0 (!qdenyn);
  endproperty
  a_act_deny: assert property (p_act_deny) else $error("low-power accepted with active count");

  property p_evt_secure;
    ce && req && !ack_reg && blk == 3'h0 && !sec_ok |=> avs_readdata == 32'h0000_0000 && !avs_waitrequest;
  endproperty
  a_evt_secure: assert property (p_evt_secure) else $error("event type visible to nonsecure read");

  property p_shd_secure;
    ce && avs_read && !ack_reg && blk == 3'h3 && !sec_ok |=> avs_readdata == 32'h0000_0000;
  endproperty
  a_shd_secure: assert property (p_shd_secure) else $error("shadow visible to nonsecure read");
endmodule // pecs_top
`default_nettype wire

// *** bench/pecs_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module pecs_top_tb;
  import pecs_pkg::*;
  // Bench drives
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic avs_secure = 1'b1;
  logic ev_valid = 1'b0;
  logic [7:0] ev_code = 8'h88;
  logic [15:0] ev_intid = 16'h0;
  logic rt_valid = 1'b0;
  logic [7:0] rt_code = 8'h90;
  logic [15:0] rt_intid = 16'h0;
  logic [7:0] rt_pend_cnt = 8'h03;
  logic [7:0] rt_act_cnt = 8'h05;
  logic shadow_capture = 1'b0;
  logic qreqn = 1'b1;
  // Design outputs
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] rt_filter_cfg;
  logic qacceptn;
  logic qdenyn;
  logic qactive;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int done_cyc = 0;

  pecs_top dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_secure(avs_secure),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ev_valid(ev_valid), .ev_code(ev_code), .ev_core(16'h0), .ev_intid(ev_intid), .ev_chip(16'h0),
    .rt_valid(rt_valid), .rt_code(rt_code), .rt_target(16'h0), .rt_intid(rt_intid),
    .rt_pend_cnt(rt_pend_cnt), .rt_act_cnt(rt_act_cnt), .rt_filter_cfg(rt_filter_cfg),
    .shadow_capture(shadow_capture), .qreqn(qreqn), .qacceptn(qacceptn), .qdenyn(qdenyn), .qactive(qactive)
  );

  // Clock and cycle count
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge sys_clk);
    #1;
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 50) begin
      bad_count++;
      $display("[FAIL] %0t bus hang", $time);
    end
    @(posedge sys_clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    done_cyc = cyc;
    #1;
    r = avs_readdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, exp, what);
  endtask

  // Enable counters for a while; span is the number of enabled edges
  task automatic window(input logic [4:0] mask, output int span);
    int t0;
    wr(8'h80, {27'h0, mask});
    t0 = done_cyc;
    repeat (6) @(posedge sys_clk);
    wr(8'h80, 32'h0);
    span = done_cyc - t0;
  endtask

  // Low-power request and answer
  task automatic qtry(input logic [1:0] exp);
    @(posedge sys_clk);
    qreqn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check({30'h0, qacceptn, qdenyn}, {30'h0, exp}, "q answer");
    @(posedge sys_clk);
    qreqn <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    print_verdict();
  end

  // Test sequence
  initial begin : main
    int s;
    int e0;
    int e1;
    int e2;
    logic [15:0] ids [3];
    ids = '{16'h12, 16'h13, 16'h14};
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdc(8'h80, 32'h0, "ctrl reset");
    rdc(8'h00, 32'h0, "type reset");
    rdc(8'h70, 32'h0, "shadow reset");
    rdc(8'h74, 32'h0, "index five");
    $display("test reset done");
    // Filters: exact, range, all
    for (int n = 0; n < 5; n++) begin
      wr(8'h00 + 8'(4 * n), 32'h88);
      wr(8'h20 + 8'(4 * n), 32'hc000_0000);
    end
    wr(8'h24, 32'h6000_0012);
    wr(8'h28, 32'h4000_0011);
    e0 = 0;
    e1 = 0;
    e2 = 0;
    ev_valid = 1'b1;
    for (int i = 0; i < 3; i++) begin
      ev_intid = ids[i];
      window(5'h07, s);
      e0 += s;
      e1 += (i == 0) ? s : 0;
      e2 += (i < 2) ? s : 0;
    end
    rdc(8'h40, e0, "all filter");
    rdc(8'h44, e1, "exact filter");
    rdc(8'h48, e2, "range filter");
    rdc(8'h4c, 32'h0, "disabled hold");
    $display("test filter done");
    // Overflow chaining
    wr(8'h04, 32'h81);
    wr(8'h08, 32'h81);
    wr(8'h40, 32'hffff_fffe);
    wr(8'h44, 32'hffff_ffff);
    wr(8'h48, 32'h0);
    window(5'h07, s);
    ev_valid = 1'b0;
    rdc(8'h40, 32'hffff_fffe + s, "wrap source");
    rdc(8'h44, 32'h0, "overflow count");
    rdc(8'h48, 32'h0, "chained overflow");
    $display("test overflow done");
    // Counter difference
    wr(8'h08, 32'h80);
    wr(8'h40, 32'h3);
    wr(8'h44, 32'ha);
    wr(8'h48, 32'h0);
    window(5'h04, s);
    rdc(8'h48, 7 * s, "difference");
    rdc(8'h40, 32'h3, "hold");
    $display("test difference done");
    // Set, activate, release
    wr(8'h00, 32'h8c);
    wr(8'h40, 32'h0);
    wr(8'h80, 32'h1);
    foreach (ids[i]) begin
      @(posedge sys_clk);
      ev_valid <= 1'b1;
      ev_code <= (i == 0) ? 8'h88 : (i == 1) ? 8'h8a : 8'h89;
      @(posedge sys_clk);
      ev_valid <= 1'b0;
      rdc(8'h40, (i == 1) ? 32'h1 : 32'h0, "set act rel");
    end
    wr(8'h80, 32'h0);
    $display("test compound done");
    // Real-time events on filter three
    wr(8'h2c, 32'h6000_0022);
    wr(8'h30, 32'h6000_0055);
    wr(8'h10, 32'h90);
    wr(8'h50, 32'h0);
    check(rt_filter_cfg, 32'h6000_0022, "rt filter out");
    rt_valid = 1'b1;
    rt_intid = 16'h22;
    window(5'h10, s);
    rt_intid = 16'h55;
    window(5'h10, e0);
    rdc(8'h50, s, "filter three");
    wr(8'h10, 32'h93);
    rt_code = 8'h93;
    rt_intid = 16'h22;
    window(5'h10, e0);
    rdc(8'h50, s, "deact filtered");
    wr(8'h2c, 32'hc000_0000);
    window(5'h10, e0);
    rdc(8'h50, s + e0, "deact open");
    rt_valid = 1'b0;
    $display("test realtime done");
    // Per-cycle real-time counts and low-power refusal
    wr(8'h08, 32'h88);
    wr(8'h4c, 32'h0);
    e1 = 0;
    for (int i = 0; i < 2; i++) begin
      wr(8'h0c, i ? 32'h95 : 32'h94);
      window(5'h08, s);
      e1 += (i ? 5 : 3) * s;
      rdc(8'h4c, e1, "rt level");
      check({31'h0, qactive}, 32'h1, "active");
      qtry(2'b10);
    end
    wr(8'h0c, 32'h88);
    check({31'h0, qactive}, 32'h0, "idle");
    qtry(2'b01);
    $display("test qchannel done");
    // Shadow capture
    for (int n = 0; n < 5; n++) begin
      wr(8'h40 + 8'(4 * n), 32'h1000_0000 + n);
    end
    @(posedge sys_clk);
    shadow_capture <= 1'b1;
    @(posedge sys_clk);
    shadow_capture <= 1'b0;
    wr(8'h40, 32'haaaa);
    for (int n = 0; n < 5; n++) begin
      rdc(8'h60 + 8'(4 * n), 32'h1000_0000 + n, "shadow");
    end
    wr(8'h60, 32'h5);
    rdc(8'h60, 32'h1000_0000, "shadow ro");
    $display("test shadow done");
    // Secure access gating
    wr(8'h00, 32'h8c);
    avs_secure = 1'b0;
    wr(8'h00, 32'h81);
    rdc(8'h00, 32'h0, "ns type");
    rdc(8'h60, 32'h0, "ns shadow");
    avs_secure = 1'b1;
    rdc(8'h00, 32'h8c, "s type");
    wr(8'h80, 32'h100);
    avs_secure = 1'b0;
    rdc(8'h00, 32'h8c, "ns type open");
    rdc(8'h60, 32'h1000_0000, "ns shadow open");
    avs_secure = 1'b1;
    $display("test secure done");
    print_verdict();
  end
endmodule // pecs_top_tb
`default_nettype wire
